// file: src/tbg_pkg.sv
// Purpose: shared constants and carrier types for the transmit baseband glue
// Assumes: 50 MHz system clock
// Notes:   frame and bias cycle counts derive from times and rates held here
package tbg_pkg;
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned SAMPLE_HZ      = 48_000;
    localparam int unsigned FRAME_CYC      = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned REF_HZ_X10     = 24;          // 2.4 MHz in units of 100 kHz
    localparam int unsigned REF_STEP       = 2 * REF_HZ_X10;
    localparam int unsigned REF_MOD        = CLK_HZ / 100_000;
    localparam int unsigned BIT_DIV        = 16;          // serial clock = MCLK / 16
    localparam int unsigned BIT_HALF       = BIT_DIV / 2;
    localparam int unsigned BIT_SAMPLE     = BIT_HALF + 4; // after two sync stages
    localparam int unsigned WORD_BITS      = 16;
    localparam int unsigned FRAME_BITS     = 2 * WORD_BITS;
    localparam int unsigned DAC_BITS       = 8;
    localparam int unsigned ATT_BITS       = 4;
    localparam int unsigned BIAS_SETTLE_NS = 2_000;
    localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
    localparam int unsigned BIAS_CYC       = (BIAS_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RAMP_BITS      = 8;
    localparam logic [7:0]  DAC_RESET      = 8'h00;
    localparam logic [7:0]  DAC_MID        = 8'h80;

    typedef struct packed {
        logic [WORD_BITS-1:0] i_word;
        logic [WORD_BITS-1:0] q_word;
    } tbg_sample_t;

    typedef struct packed {
        logic [DAC_BITS-1:0] i_code;
        logic [DAC_BITS-1:0] q_code;
    } tbg_dac_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_SLOT,
        TX_BIAS,
        TX_ON,
        TX_DOWN
    } tbg_tx_state_t;

    typedef enum logic [1:0] {
        TR_IDLE,
        TR_RISE,
        TR_HOLD,
        TR_DECAY
    } tbg_train_state_t;
endpackage : tbg_pkg

// file: src/tbg_deser.sv
// Purpose: serial-to-parallel capture of one I/Q frame
// Assumes: bit_strobe marks a stable data sample, start marks the sync bit
// Notes:   bits past the second word are filler and are ignored
`timescale 1ns/100ps
`default_nettype none
module tbg_deser (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // serial side
    input  wire logic                  bit_strobe,
    input  wire logic                  start,
    input  wire logic                  sdata,
    // parallel side
    output tbg_pkg::tbg_sample_t       sample,
    output logic                       sample_valid
);
    import tbg_pkg::*;

    logic [FRAME_BITS-1:0] shreg;
    logic [5:0]            bit_cnt;
    logic                  busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg        <= '0;
            bit_cnt      <= 6'h00;
            busy         <= 1'b0;
            sample       <= '0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= 1'b0;
            if (bit_strobe && start) begin
                busy    <= 1'b1;
                bit_cnt <= 6'h00;
            end else if (bit_strobe && busy) begin
                shreg   <= {shreg[FRAME_BITS-2:0], sdata};
                bit_cnt <= bit_cnt + 6'h01;
                if (bit_cnt == 6'(FRAME_BITS - 1)) begin
                    // fill bits after this point are never shifted in
                    busy         <= 1'b0;
                    sample       <= {shreg[FRAME_BITS-2:0], sdata};
                    sample_valid <= 1'b1;
                end
            end
        end
    end
endmodule : tbg_deser
`default_nettype wire

// file: src/tbg_ramp.sv
// Purpose: level-set training ramp with hold and decay
// Assumes: step is a one-cycle pulse at the sample rate
// Notes:   attenuation is taken from the ramp level when the error trips
`timescale 1ns/100ps
`default_nettype none
module tbg_ramp (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // control
    input  wire logic                  step,
    input  wire logic                  train,
    input  wire logic                  err_over,
    // results
    output logic [tbg_pkg::RAMP_BITS-1:0] level,
    output logic [tbg_pkg::ATT_BITS-1:0]  atten,
    output logic                       active
);
    import tbg_pkg::*;

    tbg_train_state_t state;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= TR_IDLE;
            level  <= '0;
            atten  <= '0;
            active <= 1'b0;
        end else begin
            case (state)
                TR_IDLE: begin
                    level <= '0;
                    if (train) begin
                        state  <= TR_RISE;
                        active <= 1'b1;
                    end
                end
                TR_RISE: begin
                    if (err_over) begin
                        state <= TR_HOLD;
                        // a higher tripping level needs less attenuation
                        atten <= ~level[RAMP_BITS-1 -: ATT_BITS];
                    end else if (step && level != '1) begin
                        level <= level + RAMP_BITS'(1);
                    end
                end
                TR_HOLD: begin
                    if (step) begin
                        state <= TR_DECAY;
                    end
                end
                TR_DECAY: begin
                    if (level == '0) begin
                        state  <= TR_IDLE;
                        active <= 1'b0;
                    end else if (step) begin
                        level <= level - RAMP_BITS'(1);
                    end
                end
                default: state <= TR_IDLE;
            endcase
        end
    end
endmodule : tbg_ramp
`default_nettype wire

// file: src/tbg_top.sv
// Purpose: transmit baseband glue between signal processor and transmitter chip
// Assumes: processor and transmitter inputs are asynchronous to MCLK
// Notes:   serial clock and frame sync are generated here, data sampled late in the bit
`timescale 1ns/100ps
`default_nettype none
module tbg_top (
    // clock and reset
    input  wire logic                     MCLK,
    input  wire logic                     RSTN,
    // processor serial port
    output logic                          SCLK,
    output logic                          FSYNC,
    input  wire logic                     SDATA,
    input  wire logic                     TRANSMIT_ENABLE_REQUEST,
    // transmitter chip
    output logic                          REF_CLK,
    output logic                          TRANSMIT_SLOT_PAIR_P,
    output logic                          TRANSMIT_SLOT_PAIR_N,
    input  wire logic                     ANTENNA_SWITCH_HANDSHAKE,
    // converters
    output tbg_pkg::tbg_dac_t             DAC,
    output logic                          DAC_LOAD,
    // amplifier and antenna
    output logic                          PA_NEG_BIAS_EN,
    output logic                          PA_SUPPLY_EN,
    output logic                          ANT_SWITCH_EN,
    // level-set training
    input  wire logic                     TRAIN_REQ,
    input  wire logic                     TRAIN_ERR_OVER,
    output logic [tbg_pkg::ATT_BITS-1:0]  STEP_ATTEN,
    output logic                          TRAIN_ACTIVE
);
    import tbg_pkg::*;

    function automatic logic [DAC_BITS-1:0] trunc8(input logic [WORD_BITS-1:0] w);
        trunc8 = w[WORD_BITS-1 -: DAC_BITS];
    endfunction : trunc8

    // two-stage synchronisers; stage one is read only by stage two
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {SDATA, TRANSMIT_ENABLE_REQUEST, ANTENNA_SWITCH_HANDSHAKE, TRAIN_REQ, TRAIN_ERR_OVER};
            sync2 <= sync1;
        end
    end
    logic sdata_s;
    logic txe_s;
    logic asw_s;
    logic train_s;
    logic err_s;
    assign {sdata_s, txe_s, asw_s, train_s, err_s} = sync2;

    logic txe_d;
    logic asw_d;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            txe_d <= 1'b0;
            asw_d <= 1'b0;
        end else begin
            txe_d <= txe_s;
            asw_d <= asw_s;
        end
    end
    logic txe_rise;
    logic txe_fall;
    logic asw_toggle;
    assign txe_rise   = txe_s & ~txe_d;
    assign txe_fall   = ~txe_s & txe_d;
    assign asw_toggle = asw_s ^ asw_d;

    // serial bit clock divider
    logic [3:0] div_cnt;
    logic       bit_strobe;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt <= 4'h0;
            SCLK    <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == 4'(BIT_DIV - 1)) ? 4'h0 : div_cnt + 4'h1;
            SCLK    <= (div_cnt < 4'(BIT_HALF));
        end
    end
    assign bit_strobe = (div_cnt == 4'(BIT_SAMPLE));

    // frame pacing; frame sync stays high for one whole bit period
    logic [10:0] frame_cnt;
    logic        fs_pending;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            frame_cnt  <= 11'h000;
            fs_pending <= 1'b0;
        end else begin
            if (frame_cnt == 11'(FRAME_CYC - 1)) begin
                frame_cnt  <= 11'h000;
                fs_pending <= 1'b1;
            end else begin
                frame_cnt <= frame_cnt + 11'h001;
                if (div_cnt == 4'h0) begin
                    fs_pending <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            FSYNC <= 1'b0;
        end else if (div_cnt == 4'h0) begin
            FSYNC <= fs_pending;
        end
    end

    // the sync seen at the sampling point lines up with the bit slot it marks
    tbg_sample_t sample;
    logic        sample_valid;
    tbg_deser u_deser (
        .clk          (MCLK),
        .rst_n        (RSTN),
        .bit_strobe   (bit_strobe),
        .start        (FSYNC),
        .sdata        (sdata_s),
        .sample       (sample),
        .sample_valid (sample_valid)
    );

    // 2.4 MHz reference by phase accumulation, jitter of one MCLK period
    logic [9:0] ref_acc;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_acc <= 10'h000;
            REF_CLK <= 1'b0;
        end else if (ref_acc + 10'(REF_STEP) >= 10'(REF_MOD)) begin
            ref_acc <= ref_acc + 10'(REF_STEP) - 10'(REF_MOD);
            REF_CLK <= ~REF_CLK;
        end else begin
            ref_acc <= ref_acc + 10'(REF_STEP);
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            TRANSMIT_SLOT_PAIR_P <= 1'b0;
            TRANSMIT_SLOT_PAIR_N <= 1'b1;
        end else if (txe_rise) begin
            TRANSMIT_SLOT_PAIR_P <= ~TRANSMIT_SLOT_PAIR_P;
            TRANSMIT_SLOT_PAIR_N <= ~TRANSMIT_SLOT_PAIR_N;
        end
    end

    // keying sequence
    tbg_tx_state_t tx_state;
    logic [7:0]    bias_cnt;
    logic          forwarding;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tx_state       <= TX_IDLE;
            bias_cnt       <= 8'h00;
            forwarding     <= 1'b0;
            PA_NEG_BIAS_EN <= 1'b0;
            PA_SUPPLY_EN   <= 1'b0;
            ANT_SWITCH_EN  <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (txe_rise) begin
                        tx_state   <= TX_SLOT;
                        forwarding <= 1'b1;
                    end
                end
                TX_SLOT: begin
                    if (txe_fall) begin
                        tx_state <= TX_DOWN;
                    end else if (asw_toggle) begin
                        tx_state       <= TX_BIAS;
                        PA_NEG_BIAS_EN <= 1'b1;
                        bias_cnt       <= 8'h00;
                    end
                end
                TX_BIAS: begin
                    if (bias_cnt == 8'(BIAS_CYC - 1)) begin
                        tx_state      <= TX_ON;
                        PA_SUPPLY_EN  <= 1'b1;
                        ANT_SWITCH_EN <= 1'b1;
                    end else begin
                        bias_cnt <= bias_cnt + 8'h01;
                    end
                end
                TX_ON: begin
                    // level, not edge: a fall during bias settling must still end the burst
                    if (!txe_s) begin
                        tx_state     <= TX_DOWN;
                        PA_SUPPLY_EN <= 1'b0;
                    end
                end
                TX_DOWN: begin
                    // supply already dropped; antenna switch and bias go last, in the same cycle
                    tx_state       <= TX_IDLE;
                    forwarding     <= 1'b0;
                    ANT_SWITCH_EN  <= 1'b0;
                    PA_NEG_BIAS_EN <= 1'b0;
                    PA_SUPPLY_EN   <= 1'b0;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // training ramp, stepped at the sample rate
    logic [RAMP_BITS-1:0] ramp_level;
    logic [ATT_BITS-1:0]  ramp_atten;
    logic                 ramp_active;
    tbg_ramp u_ramp (
        .clk      (MCLK),
        .rst_n    (RSTN),
        .step     (sample_valid),
        .train    (train_s),
        .err_over (err_s),
        .level    (ramp_level),
        .atten    (ramp_atten),
        .active   (ramp_active)
    );

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            STEP_ATTEN   <= '0;
            TRAIN_ACTIVE <= 1'b0;
        end else begin
            STEP_ATTEN   <= ramp_atten;
            TRAIN_ACTIVE <= ramp_active;
        end
    end

    // converter loading
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            DAC      <= '{i_code: DAC_RESET, q_code: DAC_RESET};
            DAC_LOAD <= 1'b0;
        end else begin
            DAC_LOAD <= 1'b0;
            if (ramp_active) begin
                if (sample_valid) begin
                    DAC      <= '{i_code: ramp_level, q_code: DAC_RESET};
                    DAC_LOAD <= 1'b1;
                end
            end else if (sample_valid && forwarding) begin
                DAC      <= '{i_code: trunc8(sample.i_word), q_code: trunc8(sample.q_word)};
                DAC_LOAD <= 1'b1;
            end else if (!forwarding) begin
                DAC <= '{i_code: DAC_RESET, q_code: DAC_RESET};
            end
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    a_slot_pair_diff: assert property (TRANSMIT_SLOT_PAIR_P != TRANSMIT_SLOT_PAIR_N)
        else $error("slot pair not complementary");
    a_slot_toggle: assert property (txe_rise |=> TRANSMIT_SLOT_PAIR_P != $past(TRANSMIT_SLOT_PAIR_P))
        else $error("slot pair did not toggle");
    a_supply_after_bias: assert property ($rose(PA_SUPPLY_EN) |-> $past(PA_NEG_BIAS_EN, 8))
        else $error("supply raised before bias settled");
    a_supply_needs_bias: assert property (PA_SUPPLY_EN |-> PA_NEG_BIAS_EN)
        else $error("supply on without bias");
    a_keying_on: assert property ((tx_state == TX_SLOT && asw_toggle && !txe_fall)
        |-> ##[1:110] (PA_SUPPLY_EN && ANT_SWITCH_EN))
        else $error("amplifier not keyed after handshake");
    a_forward_gate: assert property ((DAC_LOAD && !$past(ramp_active)) |-> $past(forwarding))
        else $error("samples forwarded before slot toggle");
    a_dac_trunc: assert property ((sample_valid && forwarding && !ramp_active)
        |=> DAC.i_code == $past(sample.i_word[15:8]) && DAC.q_code == $past(sample.q_word[15:8]))
        else $error("converter words not truncated upper bytes");
    a_ramp_source: assert property ((sample_valid && ramp_active) |=> DAC.q_code == DAC_RESET)
        else $error("training did not use ramp");
    a_frame_rate: assert property ($rose(FSYNC) |=> !$rose(FSYNC) [*8])
        else $error("frame sync too frequent");
    // edges since the reference last changed; a run is 10 or 11 cycles
    logic       ref_prev;
    logic [3:0] ref_hold;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_prev <= 1'b0;
            ref_hold <= 4'h0;
        end else begin
            ref_prev <= REF_CLK;
            ref_hold <= (REF_CLK != ref_prev) ? 4'h0 : ref_hold + 4'h1;
        end
    end
    a_ref_toggles: assert property (ref_hold <= 4'((REF_MOD + REF_STEP - 1) / REF_STEP))
        else $error("reference clock stalled");
endmodule : tbg_top
`default_nettype wire

// file: test/tbg_partner.sv
// Purpose: processor serial port and transmitter handshake model
// Assumes: sample bits change just after each serial clock rise
// Notes:   filler bits are random so a capture past bit 31 shows up in the codes
`timescale 1ns/100ps
`default_nettype none
module tbg_partner (
    // serial port
    input  wire logic   MCLK,
    input  wire logic   SCLK,
    input  wire logic   FSYNC,
    output logic        SDATA,
    // transmitter side
    input  wire logic   DAC_LOAD,
    input  wire logic   fwd,
    input  wire logic   kick,
    output logic        ANTENNA_SWITCH_HANDSHAKE
);
    import tbg_pkg::*;
    tbg_sample_t exp_q[$];
    tbg_sample_t cur;
    int          bitn = 99;
    logic        take = 1'b0;
    logic        sent = 1'b0;

    initial begin
        SDATA = 1'b0;
        ANTENNA_SWITCH_HANDSHAKE = 1'b0;
    end

    always @(posedge SCLK) begin
        #1;
        if (FSYNC === 1'b1) begin
            bitn = 0;
            take = fwd;
            cur  = tbg_sample_t'($urandom);
        end else if (bitn < FRAME_BITS) begin
            SDATA = cur[FRAME_BITS-1-bitn];
            bitn++;
            if (bitn == FRAME_BITS && take)
                exp_q.push_back(cur);
        end else begin
            SDATA = 1'($urandom);
        end
    end

    always @(posedge MCLK) begin
        #2;
        if (kick === 1'b1 || (DAC_LOAD === 1'b1 && fwd && !sent)) begin
            ANTENNA_SWITCH_HANDSHAKE = ~ANTENNA_SWITCH_HANDSHAKE;
            sent = fwd;
        end
        if (!fwd)
            sent = 1'b0;
    end
endmodule : tbg_partner
`default_nettype wire

// file: test/tbg_top_tb.sv
// Purpose: self-checking bench for the transmit baseband glue
// Assumes: partner model stands in for processor and transmitter
// Notes:   keying edges sit in frame filler so forwarding starts on a frame boundary
`timescale 1ns/100ps
`default_nettype none
module tbg_top_tb;
    import tbg_pkg::*;
    logic                mclk = 1'b0;
    logic                rstn = 1'b0;
    logic                transmit_enable_request = 1'b0;
    logic                tr_req = 1'b0;
    logic                tr_err = 1'b0;
    logic                kick = 1'b0;
    logic                fwd = 1'b0;
    logic                train = 1'b0;
    logic                keyed = 1'b0;
    logic                sclk, fsync, sdata, ref_clk, slot_p, slot_n, hs;
    logic                dac_load, neg_bias, supply, ant, tr_act;
    logic [ATT_BITS-1:0] atten;
    tbg_dac_t            dac;
    tbg_sample_t         e;
    int                  n_fail = 0;
    int                  cmp_count = 0;
    int                  cyc = 0;
    int                  ref_n = 0;

    tbg_top tbg_top_i (.MCLK(mclk), .RSTN(rstn), .SCLK(sclk), .FSYNC(fsync), .SDATA(sdata),
        .TRANSMIT_ENABLE_REQUEST(transmit_enable_request), .REF_CLK(ref_clk), .TRANSMIT_SLOT_PAIR_P(slot_p),
        .TRANSMIT_SLOT_PAIR_N(slot_n), .ANTENNA_SWITCH_HANDSHAKE(hs), .DAC(dac), .DAC_LOAD(dac_load),
        .PA_NEG_BIAS_EN(neg_bias), .PA_SUPPLY_EN(supply), .ANT_SWITCH_EN(ant), .TRAIN_REQ(tr_req),
        .TRAIN_ERR_OVER(tr_err), .STEP_ATTEN(atten), .TRAIN_ACTIVE(tr_act));

    tbg_partner tbg_partner_i (.MCLK(mclk), .SCLK(sclk), .FSYNC(fsync), .SDATA(sdata), .DAC_LOAD(dac_load),
        .fwd(fwd), .kick(kick), .ANTENNA_SWITCH_HANDSHAKE(hs));

    always #10 mclk = ~mclk;

    always @(posedge ref_clk) ref_n++;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // ceiling leaves headroom over the planned run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            $display("[FAIL] run length expected below 80000 cycles seen 80000");
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (int k = 0; k < lim && s !== v; k++)
            step(1);
    endtask : wait_lvl

    // park just past the data bits of a frame
    task automatic to_filler();
        @(posedge fsync);
        step(600);
    endtask : to_filler

    // result watcher: takes the oldest note at each converter load outside training
    always @(negedge mclk) begin
        if (rstn) begin
            if (dac_load === 1'b1 && !train) begin
                if (tbg_partner_i.exp_q.size() == 0) begin
                    chk("unexpected dac load", 16'h0, 16'h1);
                end else begin
                    e = tbg_partner_i.exp_q.pop_front();
                    chk("dac codes", {e.i_word[WORD_BITS-1 -: DAC_BITS], e.q_word[WORD_BITS-1 -: DAC_BITS]}, dac);
                end
            end
            if (!keyed)
                chk("dac before keying", 16'h0, dac);
            if (supply === 1'b1)
                chk("bias under supply", 16'h1, neg_bias);
        end
    end

    initial begin
        int         k;
        logic       slot0;
        logic [7:0] lvl;
        k = $urandom(32'h1be2);
        lvl = 8'h00;
        step(6);
        chk("reset outputs", 16'h0, {sclk, fsync, ref_clk, slot_p, dac_load, neg_bias, supply, ant, tr_act});
        chk("reset slot n", 16'h1, slot_n);
        chk("reset dac", 16'h0, dac);
        chk("reset atten", 16'h0, atten);
        rstn = 1'b1;
        $display("test reset done");

        @(posedge fsync);
        k = cyc;
        @(negedge fsync);
        chk("sync width", 16'(BIT_DIV), 16'(cyc - k));
        // sync snaps to bit boundaries, so sixteen frames land on a whole count
        repeat (16) @(posedge fsync);
        chk("sixteen frame periods", 16'(16 * FRAME_CYC), 16'(cyc - k));
        step(1);
        k = ref_n;
        step(5000);
        chk("ref clock edges", 16'h1, (ref_n - k) inside {[239:241]});
        $display("test clocks done");

        // a handshake with no slot open must not key the amplifier
        kick = 1'b1;
        // partner samples 2 ns after each clock rise, so the kick must span one of its looks
        step(2);
        kick = 1'b0;
        step(300);
        chk("idle handshake ignored", 16'h0, {neg_bias, supply, ant});
        $display("test stray handshake done");

        to_filler();
        slot0 = slot_p;
        transmit_enable_request = 1'b1;
        fwd = 1'b1;
        keyed = 1'b1;
        step(8);
        chk("slot p toggled", {~slot0}, slot_p);
        chk("slot pair complement", 16'h1, slot_p ^ slot_n);
        wait_lvl(neg_bias, 1'b1, 3000);
        chk("supply waits for bias", 16'h4, {neg_bias, supply, ant});
        wait_lvl(supply, 1'b1, 300);
        chk("transmit on", 16'h7, {neg_bias, supply, ant});
        repeat (3) to_filler();
        transmit_enable_request = 1'b0;
        fwd = 1'b0;
        step(10);
        chk("transmit off", 16'h0, {supply, ant});
        to_filler();
        transmit_enable_request = 1'b1;
        fwd = 1'b1;
        step(8);
        chk("slot p back", slot0, slot_p);
        wait_lvl(supply, 1'b1, 3000);
        chk("second burst on", 16'h3, {supply, ant});
        to_filler();
        transmit_enable_request = 1'b0;
        fwd = 1'b0;
        step(10);
        chk("pending samples", 16'h0, 16'(tbg_partner_i.exp_q.size()));
        $display("test keying done");

        train = 1'b1;
        tr_req = 1'b1;
        step(4);
        chk("training active", 16'h1, tr_act);
        tr_req = 1'b0;
        for (int i = 0; i < 8; i++) begin
            step(1);
            wait_lvl(dac_load, 1'b1, 1200);
            chk("ramp q zero", 16'h0, dac.q_code);
            if (i > 0)
                chk("ramp step", {lvl + 8'h01}, dac.i_code);
            lvl = dac.i_code;
        end
        // the ramp has already stepped once past the last code shown
        lvl = lvl + 8'h01;
        tr_err = 1'b1;
        step(10);
        chk("atten from level", {~lvl[7:4]}, atten);
        tr_err = 1'b0;
        for (int i = 0; i < 40 && tr_act === 1'b1; i++) begin
            step(1);
            wait_lvl(dac_load, 1'b1, 1200);
            if (dac_load === 1'b1) begin
                chk("ramp not rising", 16'h1, dac.i_code <= lvl);
                lvl = dac.i_code;
            end
        end
        chk("decay last step", 16'h1, lvl);
        chk("training over at zero", 16'h0, {tr_act, dac.i_code});
        $display("test training done");
        step(20);
        test_done();
    end
endmodule : tbg_top_tb
`default_nettype wire
